// ---- hdl/sbrg_map.vh ----
`ifndef SBRG_MAP_VH
`define SBRG_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define SBRG_CTRL0_OFS      8'h00
`define SBRG_TCONST0_OFS    8'h10
`define SBRG_INTR_CR2_OFS   8'h20
`define SBRG_INTR_CR3_OFS   8'h24
`define SBRG_VECT2_OFS      8'h28
`define SBRG_VECT3_OFS      8'h2c
`define SBRG_STATUS_OFS     8'h30
`define SBRG_MASK_OFS       8'h34
`define SBRG_STATE_OFS      8'h38

// ****************************************
// Divider control fields
// ****************************************
`define SBRG_CTRL_EN        0
`define SBRG_CTRL_PRE64     1
`define SBRG_CTRL_ROUTE_LO  2
`define SBRG_CTRL_ROUTE_HI  3
`define SBRG_CTRL_MODE_LO   6
`define SBRG_CTRL_MODE_HI   7
`define SBRG_ROUTE_NONE     2'h0
`define SBRG_ROUTE_TX       2'h1
`define SBRG_ROUTE_RX       2'h2
`define SBRG_ROUTE_BOTH     2'h3

// ****************************************
// Interrupter control fields
// ****************************************
`define SBRG_CR_FLAG        7
`define SBRG_CR_FAC         6
`define SBRG_CR_EXT         5
`define SBRG_CR_ENABLE      4
`define SBRG_CR_AUTOCLR     3

// ****************************************
// Reset values and divider constants
// ****************************************
`define SBRG_CTRL_RST       8'h00
`define SBRG_TCONST_RST     8'h00
`define SBRG_CR_RST         8'h00
`define SBRG_VECT_RST       8'h0f
`define SBRG_HALF_PRE4      5'h01
`define SBRG_HALF_PRE64     5'h1f
`define SBRG_TC_ZERO_LOAD   9'h100
`define SBRG_MODE_X1        6'h00
`define SBRG_MODE_X16       6'h0f
`define SBRG_MODE_X32       6'h1f
`define SBRG_MODE_X64       6'h3f
`define SBRG_OSC_DIV        8'h28

`endif

// ---- hdl/sbrg_rate_divider.v ----
`timescale 1ns/10ps
`include "sbrg_map.vh"

module sbrg_rate_divider (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Oscillator rate enable
  input  wire       osc_tick,
  // Settings
  input  wire       enable,
  input  wire       pre64,
  input  wire [7:0] time_const_reg,
  input  wire [1:0] clk_mode,
  // Outputs
  output reg        div_out,
  output reg        char_tick
);

  // ****************************************
  // Input stage and prescaler
  // ****************************************
  reg        in_ff;
  reg  [4:0] pre_cnt;
  reg  [8:0] down_cnt;
  reg  [5:0] mode_cnt;
  wire [4:0] pre_half;
  wire [8:0] tc_load;
  reg  [5:0] mode_max;

  assign pre_half = pre64 ? `SBRG_HALF_PRE64 : `SBRG_HALF_PRE4;
  // Zero loads as a full 256 count
  assign tc_load = (time_const_reg == 8'h00) ? `SBRG_TC_ZERO_LOAD
                                             : {1'b0, time_const_reg};

  always @* begin
    case (clk_mode)
      2'h0:    mode_max = `SBRG_MODE_X1;
      2'h1:    mode_max = `SBRG_MODE_X16;
      2'h2:    mode_max = `SBRG_MODE_X32;
      default: mode_max = `SBRG_MODE_X64;
    endcase
  end

  // The extra stage caps output at a quarter of the input rate
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_ff <= 1'b0;
    end else begin
      in_ff <= osc_tick;
    end
  end

  // ****************************************
  // Down counter and output toggle
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt   <= 5'h00;
      down_cnt  <= `SBRG_TC_ZERO_LOAD;
      div_out   <= 1'b0;
      mode_cnt  <= 6'h00;
      char_tick <= 1'b0;
    end else if (!enable) begin
      // Disabled divider reloads, so a new constant starts cleanly
      pre_cnt   <= 5'h00;
      down_cnt  <= tc_load;
      div_out   <= 1'b0;
      mode_cnt  <= 6'h00;
      char_tick <= 1'b0;
    end else begin
      char_tick <= 1'b0;
      if (in_ff) begin
        if (pre_cnt == pre_half) begin
          pre_cnt <= 5'h00;
          if (down_cnt <= 9'h001) begin
            down_cnt <= tc_load;
            div_out  <= ~div_out;
            if (!div_out) begin
              // Rate = osc / (prescale * constant * mode)
              if (mode_cnt >= mode_max) begin
                mode_cnt  <= 6'h00;
                char_tick <= 1'b1;
              end else begin
                mode_cnt <= mode_cnt + 6'h01;
              end
            end
          end else begin
            down_cnt <= down_cnt - 9'h001;
          end
        end else begin
          pre_cnt <= pre_cnt + 5'h01;
        end
      end
    end
  end

endmodule // sbrg_rate_divider

// ---- hdl/sbrg_top.v ----
`timescale 1ns/10ps
`include "sbrg_map.vh"

// How it works
// - each channel has 8-bit constant, down counter, control and toggle output.
// - input flip-flop limits output to a quarter of the input rate.
// - fastest output is divide-by-four with constant one.
// - route selects transmit, receive, both or neither clock drive.
// - prescale bit zero divides by 4, one divides by 64.
// - control bits 7 and 6 pick x1, x16, x32 or x64 mode.
// - 9600 baud from 4.9152 MHz is div4, constant 0x80, x1.
// - interrupter ch3 takes serial 0 and 1; ch2 takes 2 and 3.
// - external-vector bit set means no vector and no dtack.
// - request passes to the bus only while its enable is set.

module sbrg_top #(
  parameter OSC_DIV = `SBRG_OSC_DIV
) (
  // AHB-Lite clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Channel clock pins
  output reg  [3:0]  transmit_clock_o,
  output reg  [3:0]  transmit_clock_oe,
  output reg  [3:0]  receive_clock_o,
  output reg  [3:0]  receive_clock_oe,
  output reg  [3:0]  char_tick,
  // Serial controller requests and acknowledge
  input  wire [3:0]  serial_req_n,
  input  wire [1:0]  iack_n,
  output reg  [1:0]  bus_req,
  output reg  [5:0]  bus_level,
  output reg  [7:0]  vector_o,
  output reg         vector_oe,
  output reg         dtack_o,
  // Interrupt
  output reg         irq
);

  // ****************************************
  // Register state
  // ****************************************
  reg  [7:0]  ctrl [0:3];
  reg  [7:0]  tconst [0:3];
  reg  [7:0]  cr [0:1];
  reg  [7:0]  vect [0:1];
  reg  [5:0]  status;
  reg  [5:0]  mask;
  reg  [7:0]  next_ctrl [0:3];
  reg  [7:0]  next_tconst [0:3];
  reg  [7:0]  next_cr [0:1];
  reg  [7:0]  next_vect [0:1];
  reg  [5:0]  next_status;
  reg  [5:0]  next_mask;
  reg  [31:0] next_rdata;
  reg         wr_pend;
  reg  [7:0]  wr_addr;
  reg         osc_tick;
  reg  [7:0]  osc_cnt;
  reg  [3:0]  req_s1;
  reg  [3:0]  req_s2;
  reg  [3:0]  req_d;
  reg  [1:0]  ack_s1;
  reg  [1:0]  ack_s2;
  reg  [1:0]  ack_d;
  wire [3:0]  div_out;
  wire [3:0]  tick_w;
  wire [1:0]  int_in;
  wire [1:0]  ack_rise;
  wire [5:0]  events;
  wire        take;
  integer     i, j, k, m, n;

  assign take = hsel & hready & htrans[1];

  // ****************************************
  // Oscillator enable
  // ****************************************
  // One clock only: the board oscillator becomes an enable pulse
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt  <= 8'h00;
      osc_tick <= 1'b0;
    end else if (osc_cnt >= OSC_DIV[7:0] - 8'h01) begin
      osc_cnt  <= 8'h00;
      osc_tick <= 1'b1;
    end else begin
      osc_cnt  <= osc_cnt + 8'h01;
      osc_tick <= 1'b0;
    end
  end

  // ****************************************
  // Rate dividers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_div
      sbrg_rate_divider u_div (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .osc_tick       (osc_tick),
        .enable         (ctrl[g][`SBRG_CTRL_EN]),
        .pre64          (ctrl[g][`SBRG_CTRL_PRE64]),
        .time_const_reg (tconst[g]),
        .clk_mode       (ctrl[g][`SBRG_CTRL_MODE_HI:`SBRG_CTRL_MODE_LO]),
        .div_out        (div_out[g]),
        .char_tick      (tick_w[g])
      );
    end
  endgenerate

  // Route choice drives a pin or leaves it as an input
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      transmit_clock_o  <= 4'h0;
      transmit_clock_oe <= 4'h0;
      receive_clock_o   <= 4'h0;
      receive_clock_oe  <= 4'h0;
      char_tick         <= 4'h0;
    end else begin
      for (j = 0; j < 4; j = j + 1) begin
        transmit_clock_oe[j] <= ctrl[j][`SBRG_CTRL_ROUTE_LO];
        receive_clock_oe[j]  <= ctrl[j][`SBRG_CTRL_ROUTE_HI];
        transmit_clock_o[j]  <= div_out[j] & ctrl[j][`SBRG_CTRL_ROUTE_LO];
        receive_clock_o[j]   <= div_out[j] & ctrl[j][`SBRG_CTRL_ROUTE_HI];
      end
      char_tick <= tick_w;
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_s1 <= 4'h0;
      req_s2 <= 4'h0;
      req_d  <= 4'h0;
      ack_s1 <= 2'h0;
      ack_s2 <= 2'h0;
      ack_d  <= 2'h0;
    end else begin
      req_s1 <= ~serial_req_n;
      req_s2 <= req_s1;
      req_d  <= req_s2;
      ack_s1 <= ~iack_n;
      ack_s2 <= ack_s1;
      ack_d  <= ack_s2;
    end
  end

  // Index 0 is interrupter ch2, index 1 is ch3
  assign int_in   = {req_s2[0] | req_s2[1], req_s2[2] | req_s2[3]};
  assign ack_rise = ack_s2 & ~ack_d;
  assign events   = {ack_rise, req_s2 & ~req_d};

  // ****************************************
  // Interrupter requests and acknowledge
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_req   <= 2'h0;
      bus_level <= 6'h00;
      vector_o  <= 8'h00;
      vector_oe <= 1'b0;
      dtack_o   <= 1'b0;
    end else begin
      for (k = 0; k < 2; k = k + 1) begin
        bus_req[k] <= int_in[k] & cr[k][`SBRG_CR_ENABLE]
                      & (cr[k][2:0] != 3'h0);
      end
      bus_level <= {cr[1][2:0], cr[0][2:0]};
      // Internal answer only when the external-vector bit is clear
      if (ack_s2[1] & ~cr[1][`SBRG_CR_EXT]) begin
        vector_o  <= vect[1];
        vector_oe <= 1'b1;
        dtack_o   <= 1'b1;
      end else if (ack_s2[0] & ~cr[0][`SBRG_CR_EXT]) begin
        vector_o  <= vect[0];
        vector_oe <= 1'b1;
        dtack_o   <= 1'b1;
      end else begin
        vector_o  <= 8'h00;
        vector_oe <= 1'b0;
        dtack_o   <= 1'b0;
      end
    end
  end

  // ****************************************
  // Register next values
  // ****************************************
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      next_ctrl[i]   = ctrl[i];
      next_tconst[i] = tconst[i];
    end
    for (i = 0; i < 2; i = i + 1) begin
      next_cr[i]   = cr[i];
      next_vect[i] = vect[i];
    end
    next_mask   = mask;
    next_status = status;
    if (wr_pend) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (wr_addr == `SBRG_CTRL0_OFS + 8'h04 * i[7:0])
          next_ctrl[i] = hwdata[7:0];
        // Constant writes while running are taken; software disables first
        if (wr_addr == `SBRG_TCONST0_OFS + 8'h04 * i[7:0])
          next_tconst[i] = hwdata[7:0];
      end
      if (wr_addr == `SBRG_INTR_CR2_OFS) next_cr[0] = hwdata[7:0];
      if (wr_addr == `SBRG_INTR_CR3_OFS) next_cr[1] = hwdata[7:0];
      if (wr_addr == `SBRG_VECT2_OFS)    next_vect[0] = hwdata[7:0];
      if (wr_addr == `SBRG_VECT3_OFS)    next_vect[1] = hwdata[7:0];
      if (wr_addr == `SBRG_MASK_OFS)     next_mask = hwdata[5:0];
      if (wr_addr == `SBRG_STATUS_OFS)
        next_status = status & ~hwdata[5:0];
    end
    // Acknowledge side effects on flag and enable
    for (i = 0; i < 2; i = i + 1) begin
      if (ack_rise[i] & next_cr[i][`SBRG_CR_FAC])
        next_cr[i][`SBRG_CR_FLAG] = 1'b0;
      if (ack_rise[i] & next_cr[i][`SBRG_CR_AUTOCLR])
        next_cr[i][`SBRG_CR_ENABLE] = 1'b0;
    end
    // A new event wins over a same-cycle clear
    next_status = next_status | events;
  end

  // ****************************************
  // Register update
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (m = 0; m < 4; m = m + 1) begin
        ctrl[m]   <= `SBRG_CTRL_RST;
        tconst[m] <= `SBRG_TCONST_RST;
      end
      for (m = 0; m < 2; m = m + 1) begin
        cr[m]   <= `SBRG_CR_RST;
        vect[m] <= `SBRG_VECT_RST;
      end
      status <= 6'h00;
      mask   <= 6'h00;
      irq    <= 1'b0;
    end else begin
      for (m = 0; m < 4; m = m + 1) begin
        ctrl[m]   <= next_ctrl[m];
        tconst[m] <= next_tconst[m];
      end
      for (m = 0; m < 2; m = m + 1) begin
        cr[m]   <= next_cr[m];
        vect[m] <= next_vect[m];
      end
      status <= next_status;
      mask   <= next_mask;
      irq    <= |(next_status & next_mask);
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Reads decode next values so a read right after a write sees it
  always @* begin
    next_rdata = 32'h0000_0000;
    for (n = 0; n < 4; n = n + 1) begin
      if (haddr[7:0] == `SBRG_CTRL0_OFS + 8'h04 * n[7:0])
        next_rdata = {24'h000000, next_ctrl[n]};
      if (haddr[7:0] == `SBRG_TCONST0_OFS + 8'h04 * n[7:0])
        next_rdata = {24'h000000, next_tconst[n]};
    end
    case (haddr[7:0])
      `SBRG_INTR_CR2_OFS: next_rdata = {24'h000000, next_cr[0]};
      `SBRG_INTR_CR3_OFS: next_rdata = {24'h000000, next_cr[1]};
      `SBRG_VECT2_OFS:    next_rdata = {24'h000000, next_vect[0]};
      `SBRG_VECT3_OFS:    next_rdata = {24'h000000, next_vect[1]};
      `SBRG_STATUS_OFS:   next_rdata = {26'h0, next_status};
      `SBRG_MASK_OFS:     next_rdata = {26'h0, next_mask};
      `SBRG_STATE_OFS:    next_rdata = {20'h00000, bus_req, tick_w,
                                        2'h0, div_out};
      default:            next_rdata = next_rdata;
    endcase
    if (haddr[31:8] != 24'h000000)
      next_rdata = 32'h0000_0000;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        wr_pend <= take & hwrite & (haddr[31:8] == 24'h000000);
        wr_addr <= haddr[7:0];
      end
      if (take & ~hwrite)
        hrdata <= next_rdata;
    end
  end

endmodule // sbrg_top

// ---- tb/sbrg_clock_sink.sv ----
`timescale 1ns/10ps
// ****
// Clock sink of serial channel 0
// ****
module sbrg_clock_sink (
  // Clock
  input  wire hclk,
  // Divider pins of channel 0
  input  wire tx_clk,
  input  wire tick,
  // Measured intervals in hclk cycles
  output int  tx_period,
  output int  tick_period
);
  int   tx_cnt = 0;
  int   tk_cnt = 0;
  logic tx_d   = 1'b0;
  // Rise to rise only, so a duty error is left to the checker
  always @(posedge hclk) begin
    tx_d   <= tx_clk;
    tx_cnt <= (tx_clk && !tx_d) ? 1 : tx_cnt + 1;
    tk_cnt <= tick ? 1 : tk_cnt + 1;
    if (tx_clk && !tx_d) begin
      tx_period <= tx_cnt;
    end
    if (tick) begin
      tick_period <= tk_cnt;
    end
  end
endmodule // sbrg_clock_sink

// ---- tb/sbrg_top_bench.sv ----
`timescale 1ns/10ps
`include "sbrg_map.vh"
// ****
// Bench
// ****
module sbrg_top_bench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0]  serial_req_n = 4'hf;
  logic [1:0]  iack_n = 2'h3;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, vector_oe, dtack_o, irq;
  wire  [3:0]  txo, txe, rxo, rxe, tick;
  wire  [1:0]  bus_req;
  wire  [5:0]  bus_level;
  wire  [7:0]  vector_o;
  int          mismatches = 0;
  int          num_checks = 0;
  int          tx_period, tick_period;
  logic [31:0] rd;
  always #2.5 hclk = ~hclk;
  sbrg_top #(.OSC_DIV(2)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .transmit_clock_o(txo),
    .transmit_clock_oe(txe), .receive_clock_o(rxo), .receive_clock_oe(rxe),
    .char_tick(tick), .serial_req_n(serial_req_n), .iack_n(iack_n),
    .bus_req(bus_req), .bus_level(bus_level), .vector_o(vector_o),
    .vector_oe(vector_oe), .dtack_o(dtack_o), .irq(irq));
  sbrg_clock_sink model_u (.hclk(hclk), .tx_clk(txo[0]), .tick(tick[0]),
    .tx_period(tx_period), .tick_period(tick_period));
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    ahb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] exp);
    ahb(1'b0, a, 8'h00);
    check(rd, {24'h0, exp});
  endtask
  task rate(input logic [7:0] c, input logic [7:0] tc, input int p, t);
    wr(`SBRG_CTRL0_OFS, 8'h00);
    wr(`SBRG_TCONST0_OFS, tc);
    wr(`SBRG_CTRL0_OFS, c);
    repeat (3 * t + 20) @(posedge hclk);
    check(tx_period, p);
    check(tick_period, t);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Tests need about 13k cycles; five times that is allowed
  initial begin
    #320000;
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`SBRG_CTRL0_OFS, `SBRG_CTRL_RST);
    rdc(`SBRG_TCONST0_OFS, `SBRG_TCONST_RST);
    rdc(`SBRG_INTR_CR3_OFS, `SBRG_CR_RST);
    rdc(`SBRG_VECT3_OFS, `SBRG_VECT_RST);
    wr(8'h3c, 8'hff);
    rdc(8'h3c, 8'h00);
    $display("test reset done");
    rate(8'h0d, 8'h01, 8, 8);
    rate(8'h4d, 8'h01, 8, 128);
    rate(8'h8d, 8'h01, 8, 256);
    rate(8'hcd, 8'h01, 8, 512);
    rate(8'h0f, 8'h01, 128, 128);
    rate(8'h0d, 8'h00, 2048, 2048);
    rate(8'h0d, 8'h80, 1024, 1024);
    $display("test rate done");
    for (int r = 0; r < 4; r++) begin
      wr(`SBRG_CTRL0_OFS, {4'h0, r[1:0], 2'h1});
      repeat (3) @(posedge hclk);
      check({30'h0, rxe[0], txe[0]}, {30'h0, r[1:0]});
    end
    $display("test route done");
    wr(`SBRG_MASK_OFS, 8'h3f);
    wr(`SBRG_INTR_CR3_OFS, 8'h33);
    serial_req_n <= 4'he;
    repeat (6) @(posedge hclk);
    check({30'h0, bus_req}, 32'h2);
    check({31'h0, irq}, 32'h1);
    iack_n <= 2'h1;
    repeat (6) @(posedge hclk);
    check({30'h0, vector_oe, dtack_o}, 32'h0);
    iack_n <= 2'h3;
    serial_req_n <= 4'hf;
    repeat (6) @(posedge hclk);
    wr(`SBRG_STATUS_OFS, 8'h3f);
    rdc(`SBRG_STATUS_OFS, 8'h00);
    wr(`SBRG_INTR_CR3_OFS, 8'h03);
    serial_req_n <= 4'hd;
    repeat (6) @(posedge hclk);
    check({30'h0, bus_req}, 32'h0);
    rdc(`SBRG_STATUS_OFS, 8'h02);
    wr(`SBRG_MASK_OFS, 8'h01);
    repeat (3) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    wr(`SBRG_MASK_OFS, 8'h02);
    repeat (3) @(posedge hclk);
    check({31'h0, irq}, 32'h1);
    wr(`SBRG_STATUS_OFS, 8'h02);
    repeat (3) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    wr(`SBRG_INTR_CR3_OFS, 8'h13);
    iack_n <= 2'h1;
    repeat (6) @(posedge hclk);
    check({22'h0, vector_oe, dtack_o, vector_o}, 32'h30f);
    iack_n <= 2'h3;
    serial_req_n <= 4'hf;
    wr(`SBRG_INTR_CR2_OFS, 8'h12);
    serial_req_n <= 4'h7;
    repeat (6) @(posedge hclk);
    check({30'h0, bus_req}, 32'h1);
    check({26'h0, bus_level}, 32'h1a);
    wr(`SBRG_INTR_CR3_OFS, 8'hdb);
    iack_n <= 2'h1;
    repeat (6) @(posedge hclk);
    check({30'h0, vector_oe, dtack_o}, 32'h3);
    iack_n <= 2'h3;
    rdc(`SBRG_INTR_CR3_OFS, 8'h4b);
    wr(`SBRG_CTRL0_OFS, 8'h00);
    ahb(1'b0, `SBRG_STATE_OFS, 8'h00);
    check(rd, 32'h400);
    $display("test interrupter done");
    print_verdict;
  end
endmodule // sbrg_top_bench
bind sbrg_top sbrg_top_props #(.OSC_DIV(OSC_DIV)) props_u (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .transmit_clock_o(transmit_clock_o), .transmit_clock_oe(transmit_clock_oe),
  .receive_clock_o(receive_clock_o), .receive_clock_oe(receive_clock_oe),
  .char_tick(char_tick), .serial_req_n(serial_req_n), .iack_n(iack_n),
  .bus_req(bus_req), .vector_oe(vector_oe), .dtack_o(dtack_o));

// ---- tb/sbrg_top_props.sv ----
`timescale 1ns/10ps
// ****
// Checker on the top ports
// ****
module sbrg_top_props #(
  parameter OSC_DIV = 40
) (
  // Clock and reset
  input wire       hclk,
  input wire       hresetn,
  // Bus answer
  input wire       hreadyout,
  input wire       hresp,
  // Channel clock pins
  input wire [3:0] transmit_clock_o,
  input wire [3:0] transmit_clock_oe,
  input wire [3:0] receive_clock_o,
  input wire [3:0] receive_clock_oe,
  input wire [3:0] char_tick,
  // Interrupter
  input wire [3:0] serial_req_n,
  input wire [1:0] iack_n,
  input wire [1:0] bus_req,
  input wire       vector_oe,
  input wire       dtack_o
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  localparam int MINRUN = 2 * OSC_DIV;
  logic [15:0] run;
  logic        seen;
  // Only a low phase that began with a fall is timed; route changes restart
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run  <= 16'h0000;
      seen <= 1'b0;
    end else if (!transmit_clock_oe[0]) begin
      run  <= 16'h0000;
      seen <= 1'b0;
    end else if (transmit_clock_o[0]) begin
      run  <= 16'h0000;
      seen <= 1'b1;
    end else begin
      run  <= run + 16'h0001;
    end
  end
  AST_BUS_OK: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  AST_TX_OE: assert property ((transmit_clock_o & ~transmit_clock_oe) == 4'h0)
    else $error("transmit clock driven while not enabled");
  AST_RX_OE: assert property ((receive_clock_o & ~receive_clock_oe) == 4'h0)
    else $error("receive clock driven while not enabled");
  AST_HALF: assert property ($rose(transmit_clock_o[0]) && seen |-> run >= MINRUN)
    else $error("divider low phase too short");
  AST_TICK: assert property (char_tick[0] |=> !char_tick[0])
    else $error("character tick longer than one cycle");
  AST_REQ3: assert property ((&serial_req_n[1:0]) [*5] |-> !bus_req[1])
    else $error("channel three request without source");
  AST_REQ2: assert property ((&serial_req_n[3:2]) [*5] |-> !bus_req[0])
    else $error("channel two request without source");
  AST_NOACK: assert property ((&iack_n) [*5] |-> !vector_oe && !dtack_o)
    else $error("vector answer without acknowledge");
  AST_DTACK: assert property (vector_oe == dtack_o)
    else $error("vector drive and dtack disagree");
  cover property ($rose(transmit_clock_o[0]));
  cover property (bus_req[1]);
  cover property (vector_oe);
endmodule // sbrg_top_props
